// ### hdl/clear_compare_decrement_ops.v
// Function
// - Clear accumulator loads the working register with 00h and sets Z.
// - Clear accumulator completes in one instruction cycle.
// - Watchdog kick zeroes the watchdog counter, and the prescaler too when it is assigned to the watchdog.
// - Watchdog kick sets the time-out and power-down flags to 1 in one cycle.
// - Zero file op writes 00h to the addressed file register 0..127 and sets Z.
// - Complement op inverts the file register, stores to work (d=0) or file (d=1), updates Z.
// - Compare op forms file minus work in two's complement and updates Z and C.
// - Compare op changes neither work nor file, only the flags, in one cycle.
// - Minus one op decrements the file register to work (d=0) or file (d=1), updates Z, one cycle.
`timescale 1ns/1ps
`include "clear_compare_decrement_consts.vh"

module clear_compare_decrement_ops (
  input  wire        clk,
  input  wire        rst,
  input  wire        wbCyc,
  input  wire        wbStb,
  input  wire        wbWe,
  input  wire [7:0]  wbAdr,
  input  wire [3:0]  wbSel,
  input  wire [31:0] wbDatI,
  output reg  [31:0] wbDatO,
  output wire        wbAck,
  output wire [7:0]  workReg,
  output wire        zeroFlag,
  output wire        carryFlag,
  output wire        timeoutFlag,
  output wire        powerdownFlag
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_EXEC  = 2'd1;
  localparam ST_DONE  = 2'd2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         ack_r;
  reg  [7:0]  work_r;
  reg         zero_r;
  reg         carry_r;
  reg         timeout_r;
  reg         powerdown_r;
  reg  [7:0]  ctrl_r;
  reg  [6:0]  fileAddr_r;
  reg  [7:0]  wdog_r;
  reg  [7:0]  presc_r;
  reg  [2:0]  opCode_r;
  reg         opDest_r;
  reg  [6:0]  opAddr_r;
  reg         isOp_r;

  wire        request;
  wire        wrLow;
  wire [7:0]  memQ;
  wire [6:0]  cmdAddr;
  wire        hitOp;
  wire        hitFdata;
  wire [7:0]  compRes;
  wire [7:0]  decRes;
  wire [8:0]  cmpDiff;
  wire        psaToWdog;
  wire        kickNow;
  wire        prescWrap;
  wire        wdogStep;

  reg         memWe;
  reg  [6:0]  memWrAddr;
  reg  [7:0]  memWrData;
  reg  [6:0]  memRdAddr;

  assign request   = wbCyc & wbStb & ~ack_r;
  assign wrLow     = wbWe & wbSel[0];
  assign cmdAddr   = wbDatI[`CMD_ADR_MSB:`CMD_ADR_LSB];
  assign hitOp     = (wbAdr == `OFS_OPCMD) & wrLow;
  assign hitFdata  = (wbAdr == `OFS_FDATA);
  assign wbAck     = ack_r;
  assign workReg   = work_r;
  assign zeroFlag  = zero_r;
  assign carryFlag = carry_r;
  assign timeoutFlag   = timeout_r;
  assign powerdownFlag = powerdown_r;
  assign psaToWdog = ctrl_r[`CTRL_PSA_BIT];

  // Results are formed from the fetched file byte in the execute cycle
  assign compRes = ~memQ;
  assign decRes  = memQ - 8'h01;
  assign cmpDiff = {1'b0, memQ} - {1'b0, work_r};

  assign kickNow = (state_r == ST_EXEC) & isOp_r &
                   (opCode_r == `OP_WDOG_KICK);

  file_ram u_file_ram (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (memWe),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdAddr (memRdAddr),
    .rdData (memQ)
  );

  // Read address is taken straight from the bus in the idle cycle so
  // that the operand is ready on the following edge
  always @* begin
    if (state_r == ST_IDLE && hitOp) begin
      memRdAddr = cmdAddr;
    end else if (state_r == ST_IDLE) begin
      memRdAddr = fileAddr_r;
    end else begin
      memRdAddr = opAddr_r;
    end
  end

  // File write port: direct data writes and operation write-back
  always @* begin
    memWe     = 1'b0;
    memWrAddr = opAddr_r;
    memWrData = `ZERO_BYTE;
    if (state_r == ST_IDLE && request && hitFdata && wrLow) begin
      memWe     = 1'b1;
      memWrAddr = fileAddr_r;
      memWrData = wbDatI[7:0];
    end else if (state_r == ST_EXEC && isOp_r) begin
      case (opCode_r)
        `OP_ZERO_FILE: begin
          memWe     = 1'b1;
          memWrData = `ZERO_BYTE;
        end
        `OP_COMPLEMENT: begin
          memWe     = opDest_r;
          memWrData = compRes;
        end
        `OP_MINUS_ONE: begin
          memWe     = opDest_r;
          memWrData = decRes;
        end
        default: begin
          memWe     = 1'b0;
        end
      endcase
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (request && (hitOp || (hitFdata && !wbWe))) begin
          state_nxt = ST_EXEC;
        end else if (request) begin
          state_nxt = ST_DONE;
        end
      end
      ST_EXEC: state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ack_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ack_r   <= (state_nxt == ST_DONE);
    end
  end

  // Latch the command fields when an operation is launched
  always @(posedge clk) begin
    if (rst) begin
      opCode_r <= `OP_CLEAR_ACC;
      opDest_r <= 1'b0;
      opAddr_r <= 7'h00;
      isOp_r   <= 1'b0;
    end else if (state_r == ST_IDLE && request) begin
      opCode_r <= wbDatI[`CMD_OP_MSB:`CMD_OP_LSB];
      opDest_r <= wbDatI[`CMD_DEST_BIT];
      opAddr_r <= hitOp ? cmdAddr : fileAddr_r;
      isOp_r   <= hitOp;
    end
  end

  // Working register and arithmetic flags
  always @(posedge clk) begin
    if (rst) begin
      work_r  <= `RST_WORK;
      zero_r  <= 1'b0;
      carry_r <= 1'b0;
    end else if (state_r == ST_EXEC && isOp_r) begin
      case (opCode_r)
        `OP_CLEAR_ACC: begin
          work_r <= `ZERO_BYTE;
          zero_r <= 1'b1;
        end
        `OP_ZERO_FILE: begin
          zero_r <= 1'b1;
        end
        `OP_COMPLEMENT: begin
          if (!opDest_r) begin
            work_r <= compRes;
          end
          zero_r <= (compRes == `ZERO_BYTE);
        end
        `OP_COMPARE: begin
          zero_r  <= (cmpDiff[7:0] == `ZERO_BYTE);
          carry_r <= ~cmpDiff[8];
        end
        `OP_MINUS_ONE: begin
          if (!opDest_r) begin
            work_r <= decRes;
          end
          zero_r <= (decRes == `ZERO_BYTE);
        end
        default: begin
          work_r <= work_r;
        end
      endcase
    end else if (state_r == ST_IDLE && request && wrLow) begin
      if (wbAdr == `OFS_WORK) begin
        work_r <= wbDatI[7:0];
      end
      if (wbAdr == `OFS_STATUS) begin
        zero_r  <= wbDatI[`ST_ZERO];
        carry_r <= wbDatI[`ST_CARRY];
      end
    end
  end

  // Control register and file address pointer
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r     <= `RST_CTRL;
      fileAddr_r <= 7'h00;
    end else if (state_r == ST_IDLE && request && wrLow) begin
      if (wbAdr == `OFS_CTRL) begin
        ctrl_r <= wbDatI[7:0];
      end
      if (wbAdr == `OFS_FADDR) begin
        fileAddr_r <= wbDatI[6:0];
      end
    end
  end

  // Prescaler feeds the watchdog only while assigned to it
  assign prescWrap = (presc_r == 8'hFF);
  assign wdogStep  = psaToWdog ? prescWrap : 1'b1;

  always @(posedge clk) begin
    if (rst) begin
      presc_r <= `ZERO_BYTE;
    end else if (kickNow && psaToWdog) begin
      presc_r <= `ZERO_BYTE;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wdog_r <= `ZERO_BYTE;
    end else if (kickNow) begin
      wdog_r <= `ZERO_BYTE;
    end else if (wdogStep) begin
      wdog_r <= wdog_r + 8'h01;
    end
  end

  // Both flags are active low; a kick wins over a same-cycle overflow
  always @(posedge clk) begin
    if (rst) begin
      timeout_r   <= 1'b1;
      powerdown_r <= 1'b1;
    end else if (kickNow) begin
      timeout_r   <= 1'b1;
      powerdown_r <= 1'b1;
    end else if (wdogStep && wdog_r == 8'hFF) begin
      timeout_r   <= 1'b0;
    end
  end

  // Read data are registered with the acknowledge
  always @(posedge clk) begin
    if (rst) begin
      wbDatO <= 32'h0000_0000;
    end else if (state_nxt == ST_DONE) begin
      wbDatO <= 32'h0000_0000;
      if (!wbWe) begin
        case (wbAdr)
          `OFS_WORK:   wbDatO[7:0] <= work_r;
          `OFS_STATUS: begin
            wbDatO[`ST_CARRY]     <= carry_r;
            wbDatO[`ST_ZERO]      <= zero_r;
            wbDatO[`ST_POWERDOWN] <= powerdown_r;
            wbDatO[`ST_TIMEOUT]   <= timeout_r;
          end
          `OFS_FADDR:  wbDatO[6:0] <= fileAddr_r;
          `OFS_FDATA:  wbDatO[7:0] <= memQ;
          `OFS_CTRL:   wbDatO[7:0] <= ctrl_r;
          `OFS_WDOG:   wbDatO[15:0] <= {presc_r, wdog_r};
          default:     wbDatO <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // clear_compare_decrement_ops

// ### hdl/clear_compare_decrement_consts.vh
`ifndef CLEAR_COMPARE_DECREMENT_CONSTS_VH
`define CLEAR_COMPARE_DECREMENT_CONSTS_VH

// Register byte offsets
`define OFS_WORK      8'h00
`define OFS_STATUS    8'h04
`define OFS_OPCMD     8'h08
`define OFS_FADDR     8'h0C
`define OFS_FDATA     8'h10
`define OFS_CTRL      8'h14
`define OFS_WDOG      8'h18

// Status bit positions
`define ST_CARRY      0
`define ST_ZERO       2
`define ST_POWERDOWN  3
`define ST_TIMEOUT    4

// Command register fields
`define CMD_OP_LSB    0
`define CMD_OP_MSB    2
`define CMD_DEST_BIT  3
`define CMD_ADR_LSB   4
`define CMD_ADR_MSB   10

// Control register fields
`define CTRL_PSA_BIT  0

// Operation codes
`define OP_CLEAR_ACC  3'h0
`define OP_WDOG_KICK  3'h1
`define OP_ZERO_FILE  3'h2
`define OP_COMPLEMENT 3'h3
`define OP_COMPARE    3'h4
`define OP_MINUS_ONE  3'h5

// Reset values
`define RST_WORK      8'h00
`define RST_FLAGS     5'h18
`define RST_CTRL      8'h01
`define ZERO_BYTE     8'h00

// Widths
`define FILE_AW       7
`define DATA_W        8

`endif

// ### hdl/file_ram.v
`timescale 1ns/1ps
module file_ram (
  input  wire       clk,
  input  wire       rst,
  input  wire       wrEn,
  input  wire [6:0] wrAddr,
  input  wire [7:0] wrData,
  input  wire [6:0] rdAddr,
  output reg  [7:0] rdData
);

  reg [7:0] cells [0:127];

  // Write and read share the clock; read data appear one edge later
  always @(posedge clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= cells[rdAddr];
    end
  end

endmodule // file_ram

// ### tb/clear_compare_decrement_ops_chk.sv
`timescale 1ns/1ps
`include "clear_compare_decrement_consts.vh"
module clear_compare_decrement_ops_chk (
  input wire        clk,
  input wire        rst,
  input wire        wbCyc,
  input wire        wbStb,
  input wire        wbWe,
  input wire [7:0]  wbAdr,
  input wire [3:0]  wbSel,
  input wire [31:0] wbDatI,
  input wire [31:0] wbDatO,
  input wire        wbAck,
  input wire [7:0]  workReg,
  input wire        zeroFlag,
  input wire        carryFlag,
  input wire        timeoutFlag,
  input wire        powerdownFlag
);
  wire       opAck = wbCyc && wbStb && wbWe && wbAck && wbSel[0]
                     && wbAdr == `OFS_OPCMD;
  wire [2:0] op    = wbDatI[2:0];
  wire       dst   = wbDatI[3];
  wire       fileOp = op == `OP_COMPLEMENT || op == `OP_MINUS_ONE;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  clr_acc_a: assert property (
    opAck && op == `OP_CLEAR_ACC |-> workReg == 8'h00 && zeroFlag)
    else $error("clear acc result wrong");
  op_lat_a: assert property (
    $rose(wbStb) && wbWe && wbSel[0] && wbAdr == `OFS_OPCMD
    |=> !wbAck ##1 wbAck) else $error("op latency wrong");
  kick_flags_a: assert property (
    opAck && op == `OP_WDOG_KICK |-> timeoutFlag && powerdownFlag)
    else $error("kick flags wrong");
  zero_file_a: assert property (
    opAck && op == `OP_ZERO_FILE |-> zeroFlag)
    else $error("zero file flag wrong");
  dest_work_a: assert property (
    opAck && fileOp && !dst |-> zeroFlag == (workReg == 8'h00))
    else $error("zero flag not from result");
  dest_file_a: assert property (
    opAck && fileOp && dst |-> workReg == $past(workReg))
    else $error("work changed on file dest");
  cmp_keep_a: assert property (
    opAck && op == `OP_COMPARE |-> $stable(workReg))
    else $error("compare changed work");
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  reg_lat_a: assert property (
    $rose(wbStb) && wbAdr == `OFS_WORK |=> wbAck)
    else $error("register ack late");
  cover property (opAck && op == `OP_COMPARE);
  cover property (opAck && op == `OP_WDOG_KICK);
  cover property (opAck && op == `OP_MINUS_ONE && dst);
endmodule // clear_compare_decrement_ops_chk

bind clear_compare_decrement_ops clear_compare_decrement_ops_chk chk (
  .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
  .wbAck(wbAck), .workReg(workReg), .zeroFlag(zeroFlag),
  .carryFlag(carryFlag), .timeoutFlag(timeoutFlag),
  .powerdownFlag(powerdownFlag));

// ### tb/clear_compare_decrement_ops_tb_top.sv
`timescale 1ns/1ps
`include "clear_compare_decrement_consts.vh"
module clear_compare_decrement_ops_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         wbCyc = 1'b0;
  reg         wbStb = 1'b0;
  reg         wbWe = 1'b0;
  reg  [7:0]  wbAdr = 8'h00;
  reg  [3:0]  wbSel = 4'h0;
  reg  [31:0] wbDatI = 32'h0;
  wire [31:0] wbDatO;
  wire        wbAck;
  wire [7:0]  workReg;
  wire        zeroFlag;
  wire        carryFlag;
  wire        timeoutFlag;
  wire        powerdownFlag;
  integer     fail_count = 0;
  integer     checked = 0;
  integer     cycles = 0;
  integer     i;
  reg  [31:0] rdv;
  reg  [17:0] e;
  // Compare cases: file value, work value, expected Z and C
  localparam [89:0] CMP = {8'h34, 8'h12, 2'b01, 8'h12, 8'h34, 2'b00,
    8'h34, 8'h34, 2'b11, 8'h00, 8'hFF, 2'b00, 8'hFF, 8'h00, 2'b01};
  always #4 clk = ~clk;
  clear_compare_decrement_ops dut (
    .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .workReg(workReg), .zeroFlag(zeroFlag),
    .carryFlag(carryFlag), .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag));
  task final_report;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A hang in any wait ends here instead of running forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    integer n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    wbSel <= s;
    @(posedge clk);
    while (wbAck !== 1'b1) begin
      @(posedge clk);
      n = n + 1;
    end
    rdv = wbDatO;
    // Ack one edge after the taken edge, two for ops and file reads
    chk(n, ((w && s[0] && a == `OFS_OPCMD) || (!w && a == `OFS_FDATA))
        ? 2 : 1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task rd(input [7:0] a, input [31:0] x);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(rdv, x);
  endtask
  task op(input [2:0] o, input dst, input [6:0] a);
    wr(`OFS_OPCMD, {21'h0, a, dst, o});
  endtask
  task fl(input [6:0] a, input [7:0] v);
    wr(`OFS_FADDR, {25'h0, a});
    wr(`OFS_FDATA, {24'h0, v});
  endtask
  // Flags are sampled at the ack edge, where the op result already shows
  task st(input [7:0] w, input z, input c);
    chk({22'h0, workReg, zeroFlag, carryFlag}, {22'h0, w, z, c});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_STATUS, 32'h18);
    rd(`OFS_CTRL, 32'h01);
    rd(8'h1C, 32'h0);
    wr(`OFS_WORK, 32'h55);
    bus(1'b1, `OFS_WORK, 32'hAA, 4'hE);
    rd(`OFS_WORK, 32'h55);
    wr(`OFS_STATUS, 32'h0);
    op(`OP_CLEAR_ACC, 1'b0, 7'h00);
    st(8'h00, 1'b1, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      fl(i ? 7'h7F : 7'h00, 8'h55);
      wr(`OFS_STATUS, 32'h0);
      op(`OP_ZERO_FILE, 1'b0, i ? 7'h7F : 7'h00);
      st(8'h00, 1'b1, 1'b0);
      rd(`OFS_FDATA, 32'h0);
    end
    fl(7'h10, 8'hA6);
    op(`OP_COMPLEMENT, 1'b1, 7'h10);
    st(8'h00, 1'b0, 1'b0);
    rd(`OFS_FDATA, 32'h59);
    op(`OP_COMPLEMENT, 1'b0, 7'h10);
    st(8'hA6, 1'b0, 1'b0);
    rd(`OFS_FDATA, 32'h59);
    fl(7'h11, 8'hFF);
    op(`OP_COMPLEMENT, 1'b0, 7'h11);
    st(8'h00, 1'b1, 1'b0);
    for (i = 0; i < 5; i = i + 1) begin
      e = CMP[i*18 +: 18];
      wr(`OFS_WORK, {24'h0, e[9:2]});
      fl(7'h20, e[17:10]);
      wr(`OFS_STATUS, {29'h0, ~e[1], 1'b0, ~e[0]});
      op(`OP_COMPARE, 1'b1, 7'h20);
      st(e[9:2], e[1], e[0]);
      rd(`OFS_FDATA, {24'h0, e[17:10]});
    end
    fl(7'h30, 8'h01);
    op(`OP_MINUS_ONE, 1'b1, 7'h30);
    st(8'h12, 1'b1, 1'b1);
    rd(`OFS_FDATA, 32'h0);
    op(`OP_MINUS_ONE, 1'b0, 7'h30);
    st(8'hFF, 1'b0, 1'b1);
    rd(`OFS_FDATA, 32'h0);
    op(3'h6, 1'b0, 7'h30);
    st(8'hFF, 1'b0, 1'b1);
    // Watchdog stepping every clock wraps quickly and drops the flag
    wr(`OFS_CTRL, 32'h0);
    repeat (300) @(posedge clk);
    chk({31'h0, timeoutFlag}, 32'h0);
    op(`OP_WDOG_KICK, 1'b0, 7'h00);
    chk({30'h0, timeoutFlag, powerdownFlag}, 32'h3);
    // Prescaler off the watchdog: a kick must leave it counting on
    rdv = 32'h0;
    for (i = 0; i < 300 && rdv[15:14] != 2'b01; i = i + 1)
      bus(1'b0, `OFS_WDOG, 32'h0, 4'hF);
    e[7:0] = rdv[15:8];
    op(`OP_WDOG_KICK, 1'b0, 7'h00);
    bus(1'b0, `OFS_WDOG, 32'h0, 4'hF);
    chk({31'h0, (rdv[15:8] - e[7:0]) < 8'h10}, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    rdv = 32'h0;
    for (i = 0; i < 300 && rdv[15:8] < 8'h80; i = i + 1)
      bus(1'b0, `OFS_WDOG, 32'h0, 4'hF);
    op(`OP_WDOG_KICK, 1'b0, 7'h00);
    bus(1'b0, `OFS_WDOG, 32'h0, 4'hF);
    chk({31'h0, rdv[15:8] < 8'h10 && rdv[7:0] == 8'h00}, 32'h1);
    final_report;
  end
endmodule // clear_compare_decrement_ops_tb_top
